// File: core/radio_cfg_pkg.sv
`default_nettype none

package radio_cfg_pkg;

  // register map
  localparam int         REG_COUNT    = 18;
  localparam int         ADDR_BITS    = 5;
  localparam logic [7:0] ADDR_PIN0    = 8'h00;
  localparam logic [7:0] ADDR_PIN1    = 8'h01;
  localparam logic [7:0] ADDR_PIN2    = 8'h02;
  localparam logic [7:0] ADDR_PIN3    = 8'h03;
  localparam logic [7:0] ADDR_SYN_TOP = 8'h05;
  localparam logic [7:0] ADDR_SYN_UPR = 8'h06;
  localparam logic [7:0] ADDR_SYN_LWR = 8'h07;
  localparam logic [7:0] ADDR_SYN_BOT = 8'h08;
  localparam logic [7:0] ADDR_IF_ANA  = 8'h09;
  localparam logic [7:0] ADDR_IF_DIG  = 8'h0a;
  localparam logic [7:0] ADDR_CH_STEP = 8'h0c;
  localparam logic [7:0] ADDR_CH_IDX  = 8'h0d;
  localparam logic [7:0] ADDR_RATE_HI = 8'h0e;
  localparam logic [7:0] ADDR_RATE_LO = 8'h0f;
  localparam logic [7:0] ADDR_MOD     = 8'h10;
  localparam logic [7:0] ADDR_PA_CTRL = 8'h11;
  localparam logic [7:0] ADDR_LAST    = 8'h11;

  // reset values, index 17 first; gaps at 0x04 and 0x0b hold nothing
  localparam logic [REG_COUNT-1:0][7:0] REG_RESET = {
    8'h00, 8'h77, 8'h2b, 8'h83, 8'h00, 8'h3f, 8'h00, 8'hb8, 8'h2a,
    8'h62, 8'h27, 8'h16, 8'h42, 8'h00, 8'ha2, 8'ha2, 8'ha2, 8'h0a};

  // writable bits; reserved and gap bits stay zero
  localparam logic [REG_COUNT-1:0][7:0] REG_MASK = {
    8'h80, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h00, 8'hff, 8'hff,
    8'hff, 8'hff, 8'hff, 8'hff, 8'h00, 8'hfb, 8'hfb, 8'hfb, 8'hfb};

  // pin configuration fields
  localparam int         PIN_SEL_HI    = 7;
  localparam int         PIN_SEL_LO    = 3;
  localparam int         PIN_RSVD_BIT  = 2;
  localparam logic [1:0] MODE_INPUT    = 2'h1;
  localparam logic [1:0] MODE_OUT_LOW  = 2'h2;
  localparam logic [1:0] MODE_OUT_HIGH = 2'h3;
  localparam logic [4:0] FUNC_IRQ      = 5'h00;
  localparam logic [4:0] FUNC_POR      = 5'h01;
  localparam logic [4:0] FUNC_VDD      = 5'h13;
  localparam logic [4:0] FUNC_GND      = 5'h14;

  // synthesizer and modulation fields
  localparam int         CP_HI         = 7;
  localparam int         CP_LO         = 5;
  localparam int         BAND_BIT      = 4;
  localparam int         KIND_HI       = 7;
  localparam int         KIND_LO       = 4;
  localparam int         EXP_HI        = 3;
  localparam int         EXP_LO        = 0;
  localparam int         PA_INTERP_BIT = 7;
  localparam logic [3:0] DIV_HIGH_BAND = 4'h4;
  localparam logic [3:0] DIV_MID_BAND  = 4'h8;

  // serial header codes
  localparam logic [7:0] CMD_WRITE = 8'h00;
  localparam logic [7:0] CMD_READ  = 8'h01;

  typedef enum logic [4:0] {
    PH_CMD   = 5'h01,
    PH_ADDR  = 5'h02,
    PH_WDATA = 5'h04,
    PH_RDATA = 5'h08,
    PH_SKIP  = 5'h10
  } spi_state_t;

endpackage

`default_nettype wire

// File: core/pin_function_mux.sv
`timescale 1ns/10ps
`default_nettype none

module pin_function_mux (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic        ce,
  // configuration byte
  input  wire logic [7:0]  cfg,
  // internal sources
  input  wire logic        interrupt_request_low,
  input  wire logic        por_low,
  input  wire logic [31:0] internal_signals,
  // pin
  input  wire logic        pin_in,
  output logic             pin_out,
  output logic             pin_oe_n,
  output logic             pin_high_drive,
  output logic             pin_in_level
);

  logic [4:0] sel;
  logic [1:0] mode;
  logic       drive;
  logic       src;
  logic       pin_out_r;
  logic       pin_in_level_r;

  assign sel  = cfg[radio_cfg_pkg::PIN_SEL_HI:radio_cfg_pkg::PIN_SEL_LO];
  assign mode = cfg[1:0];
  // analog mode (00) also leaves the pin undriven
  assign drive = (mode == radio_cfg_pkg::MODE_OUT_LOW) ||
                 (mode == radio_cfg_pkg::MODE_OUT_HIGH);

  always_comb begin
    case (sel)
      radio_cfg_pkg::FUNC_IRQ: src = interrupt_request_low;
      radio_cfg_pkg::FUNC_POR: src = por_low;
      radio_cfg_pkg::FUNC_VDD: src = 1'b1;
      radio_cfg_pkg::FUNC_GND: src = 1'b0;
      default:                 src = internal_signals[sel];
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pin_out_r <= 1'b0;
    end else if (ce) begin
      pin_out_r <= drive ? src : 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pin_in_level_r <= 1'b0;
    end else if (ce) begin
      pin_in_level_r <= (mode == radio_cfg_pkg::MODE_INPUT) ? pin_in : 1'b0;
    end
  end

  assign pin_out        = pin_out_r;
  assign pin_oe_n       = !drive;
  assign pin_high_drive = (mode == radio_cfg_pkg::MODE_OUT_HIGH);
  assign pin_in_level   = pin_in_level_r;

  a_gnd_func_low: assert property (@(posedge core_clk) disable iff (!rstn)
    (ce && drive && sel == radio_cfg_pkg::FUNC_GND) |=> !pin_out)
    else $error("ground function pin not low");

  a_por_func_route: assert property (@(posedge core_clk) disable iff (!rstn)
    (ce && drive && sel == radio_cfg_pkg::FUNC_POR) |=> pin_out == $past(por_low))
    else $error("power-on reset not routed to pin");

  a_input_mode_float: assert property (@(posedge core_clk) disable iff (!rstn)
    (mode == radio_cfg_pkg::MODE_INPUT) |-> (pin_oe_n && !pin_high_drive))
    else $error("input pin is driven");

endmodule

`default_nettype wire

// File: core/radio_cfg_regs.sv
`timescale 1ns/10ps
`default_nettype none

module radio_cfg_regs #(
  parameter int PIN_COUNT = 4
) (
  // clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 rstn,
  input  wire logic                 ce,
  // serial register port, mode 0, msb first
  input  wire logic                 chip_select_low,
  input  wire logic                 sclk,
  input  wire logic                 mosi,
  output logic                      miso,
  output logic                      miso_oe_n,
  // internal pin sources
  input  wire logic                 interrupt_request_low,
  input  wire logic                 por_low,
  input  wire logic [31:0]          internal_signals,
  // pins
  input  wire logic [PIN_COUNT-1:0] pin_in,
  output logic      [PIN_COUNT-1:0] pin_out,
  output logic      [PIN_COUNT-1:0] pin_oe_n,
  output logic      [PIN_COUNT-1:0] pin_high_drive,
  output logic      [PIN_COUNT-1:0] pin_in_level,
  // synthesizer settings
  output logic      [2:0]           charge_pump_current_code,
  output logic                      synth_band_divide_select,
  output logic      [3:0]           out_of_loop_divide,
  output logic      [27:0]          pll_divider_word,
  output logic      [7:0]           analog_intermediate_freq,
  output logic      [7:0]           digital_intermediate_freq,
  // channel settings
  output logic      [7:0]           channel_step,
  output logic      [7:0]           channel_index,
  output logic      [15:0]          channel_offset,
  // modulation settings
  output logic      [15:0]          rate_mantissa,
  output logic      [3:0]           rate_exponent,
  output logic      [3:0]           modulation_kind,
  output logic                      power_amp_interpolator_on
);

  localparam int RC = radio_cfg_pkg::REG_COUNT;
  localparam int AB = radio_cfg_pkg::ADDR_BITS;

  logic [RC-1:0][7:0]        regs_r;
  radio_cfg_pkg::spi_state_t state_r;
  logic                      sclk_q_r;
  logic [2:0]                bit_cnt_r;
  logic [7:0]                rx_shift_r;
  logic [7:0]                tx_shift_r;
  logic [7:0]                addr_r;
  logic [15:0]               channel_offset_r;
  logic                      sclk_rise;
  logic                      sclk_fall;
  logic                      byte_done;
  logic [7:0]                rx_byte;
  logic [7:0]                addr_nxt;
  logic                      wr_en;
  logic                      rd_mode_r;

  function automatic logic [7:0] read_reg(input logic [RC-1:0][7:0] bank,
                                          input logic [7:0]         a);
    if (a <= radio_cfg_pkg::ADDR_LAST) begin
      read_reg = bank[a[AB-1:0]];
    end else begin
      read_reg = 8'h00;
    end
  endfunction

  // edge detect on the serial clock; pins are already in the core clock domain
  assign sclk_rise = !chip_select_low && sclk && !sclk_q_r;
  assign sclk_fall = !chip_select_low && !sclk && sclk_q_r;
  assign byte_done = sclk_rise && (bit_cnt_r == 3'h7);
  assign rx_byte   = {rx_shift_r[6:0], mosi};
  assign addr_nxt  = addr_r + 8'h01;
  // writes past the last register are dropped, gaps keep a zero mask
  assign wr_en     = ce && byte_done && (state_r == radio_cfg_pkg::PH_WDATA) &&
                     (addr_r <= radio_cfg_pkg::ADDR_LAST);

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sclk_q_r <= 1'b0;
    end else if (ce) begin
      sclk_q_r <= sclk;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      bit_cnt_r <= 3'h0;
    end else if (ce) begin
      if (chip_select_low) begin
        bit_cnt_r <= 3'h0;
      end else if (sclk_rise) begin
        bit_cnt_r <= bit_cnt_r + 3'h1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rx_shift_r <= 8'h00;
    end else if (ce && sclk_rise) begin
      rx_shift_r <= rx_byte;
    end
  end

  // header byte, address byte, then data bytes until chip select rises
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= radio_cfg_pkg::PH_CMD;
    end else if (ce) begin
      if (chip_select_low) begin
        state_r <= radio_cfg_pkg::PH_CMD;
      end else if (byte_done) begin
        case (state_r)
          radio_cfg_pkg::PH_CMD: begin
            if (rx_byte == radio_cfg_pkg::CMD_WRITE || rx_byte == radio_cfg_pkg::CMD_READ) begin
              state_r <= radio_cfg_pkg::PH_ADDR;
            end else begin
              state_r <= radio_cfg_pkg::PH_SKIP;
            end
          end
          radio_cfg_pkg::PH_ADDR: begin
            state_r <= rd_mode_r ? radio_cfg_pkg::PH_RDATA : radio_cfg_pkg::PH_WDATA;
          end
          radio_cfg_pkg::PH_WDATA: state_r <= radio_cfg_pkg::PH_WDATA;
          radio_cfg_pkg::PH_RDATA: state_r <= radio_cfg_pkg::PH_RDATA;
          radio_cfg_pkg::PH_SKIP:  state_r <= radio_cfg_pkg::PH_SKIP;
          default:                 state_r <= radio_cfg_pkg::PH_CMD;
        endcase
      end
    end
  end

  // header kind is kept for the whole frame, data bytes never reload it

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rd_mode_r <= 1'b0;
    end else if (ce && byte_done && state_r == radio_cfg_pkg::PH_CMD) begin
      rd_mode_r <= (rx_byte == radio_cfg_pkg::CMD_READ);
    end
  end

  // address loads from the address byte, then steps after every data byte
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      addr_r <= 8'h00;
    end else if (ce && byte_done) begin
      if (state_r == radio_cfg_pkg::PH_ADDR) begin
        addr_r <= rx_byte;
      end else if (state_r == radio_cfg_pkg::PH_WDATA || state_r == radio_cfg_pkg::PH_RDATA) begin
        addr_r <= addr_nxt;
      end
    end
  end

  // read byte is fetched at the end of the previous byte, so the msb is ready
  // before the first rising edge; shifting skips the fall that follows a fetch
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      tx_shift_r <= 8'h00;
    end else if (ce) begin
      if (chip_select_low) begin
        tx_shift_r <= 8'h00;
      end else if (byte_done && state_r == radio_cfg_pkg::PH_ADDR && rd_mode_r) begin
        tx_shift_r <= read_reg(regs_r, rx_byte);
      end else if (byte_done && state_r == radio_cfg_pkg::PH_RDATA) begin
        tx_shift_r <= read_reg(regs_r, addr_nxt);
      end else if (sclk_fall && bit_cnt_r != 3'h0) begin
        tx_shift_r <= {tx_shift_r[6:0], 1'b0};
      end
    end
  end

  assign miso      = tx_shift_r[7];
  assign miso_oe_n = chip_select_low;

  // register bank; reset loads the defaults, writes pass through the mask
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      regs_r <= radio_cfg_pkg::REG_RESET;
    end else if (wr_en) begin
      regs_r[addr_r[AB-1:0]] <= rx_byte & radio_cfg_pkg::REG_MASK[addr_r[AB-1:0]];
    end
  end

  // product is registered; it lags a channel write by one cycle
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      channel_offset_r <= 16'h0000;
    end else if (ce) begin
      channel_offset_r <= {8'h00, channel_index} * {8'h00, channel_step};
    end
  end

  assign charge_pump_current_code =
    regs_r[radio_cfg_pkg::ADDR_SYN_TOP][radio_cfg_pkg::CP_HI:radio_cfg_pkg::CP_LO];
  assign synth_band_divide_select =
    regs_r[radio_cfg_pkg::ADDR_SYN_TOP][radio_cfg_pkg::BAND_BIT];
  assign out_of_loop_divide = synth_band_divide_select ? radio_cfg_pkg::DIV_MID_BAND :
                                                         radio_cfg_pkg::DIV_HIGH_BAND;
  assign pll_divider_word = {regs_r[radio_cfg_pkg::ADDR_SYN_TOP][3:0],
                             regs_r[radio_cfg_pkg::ADDR_SYN_UPR],
                             regs_r[radio_cfg_pkg::ADDR_SYN_LWR],
                             regs_r[radio_cfg_pkg::ADDR_SYN_BOT]};
  assign analog_intermediate_freq  = regs_r[radio_cfg_pkg::ADDR_IF_ANA];
  assign digital_intermediate_freq = regs_r[radio_cfg_pkg::ADDR_IF_DIG];
  assign channel_step   = regs_r[radio_cfg_pkg::ADDR_CH_STEP];
  assign channel_index  = regs_r[radio_cfg_pkg::ADDR_CH_IDX];
  assign channel_offset = channel_offset_r;
  assign rate_mantissa  = {regs_r[radio_cfg_pkg::ADDR_RATE_HI],
                           regs_r[radio_cfg_pkg::ADDR_RATE_LO]};
  assign modulation_kind =
    regs_r[radio_cfg_pkg::ADDR_MOD][radio_cfg_pkg::KIND_HI:radio_cfg_pkg::KIND_LO];
  assign rate_exponent =
    regs_r[radio_cfg_pkg::ADDR_MOD][radio_cfg_pkg::EXP_HI:radio_cfg_pkg::EXP_LO];
  assign power_amp_interpolator_on =
    regs_r[radio_cfg_pkg::ADDR_PA_CTRL][radio_cfg_pkg::PA_INTERP_BIT];

  genvar g;
  generate
    for (g = 0; g < PIN_COUNT; g++) begin : g_pin
      pin_function_mux u_pin (
        .core_clk              (core_clk),
        .rstn                  (rstn),
        .ce                    (ce),
        .cfg                   (regs_r[g]),
        .interrupt_request_low (interrupt_request_low),
        .por_low               (por_low),
        .internal_signals      (internal_signals),
        .pin_in                (pin_in[g]),
        .pin_out               (pin_out[g]),
        .pin_oe_n              (pin_oe_n[g]),
        .pin_high_drive        (pin_high_drive[g]),
        .pin_in_level          (pin_in_level[g])
      );
    end
  endgenerate

  a_reset_pin_defaults: assert property (@(posedge core_clk)
    $rose(rstn) |-> (regs_r[0] == 8'h0a && regs_r[1] == 8'ha2 &&
                     regs_r[2] == 8'ha2 && regs_r[3] == 8'ha2))
    else $error("pin configuration defaults wrong after reset");

  a_reset_synth_defaults: assert property (@(posedge core_clk)
    $rose(rstn) |-> (analog_intermediate_freq == 8'h2a && digital_intermediate_freq == 8'hb8 &&
                     channel_step == 8'h3f && channel_index == 8'h00 &&
                     regs_r[radio_cfg_pkg::ADDR_MOD] == 8'h77))
    else $error("synthesizer or modulation defaults wrong after reset");

  a_write_readback: assert property (@(posedge core_clk) disable iff (!rstn)
    wr_en |=> regs_r[$past(addr_r[AB-1:0])] ==
              ($past(rx_byte) & radio_cfg_pkg::REG_MASK[$past(addr_r[AB-1:0])]))
    else $error("written byte not stored");

  a_reserved_zero: assert property (@(posedge core_clk) disable iff (!rstn)
    (regs_r[0][2] == 1'b0 && regs_r[4] == 8'h00 && regs_r[11] == 8'h00 &&
     regs_r[radio_cfg_pkg::ADDR_PA_CTRL][6:0] == 7'h00))
    else $error("reserved bits not zero");

  a_burst_increment: assert property (@(posedge core_clk) disable iff (!rstn)
    (ce && byte_done && (state_r == radio_cfg_pkg::PH_WDATA ||
                         state_r == radio_cfg_pkg::PH_RDATA)) |=> addr_r == $past(addr_nxt))
    else $error("burst address did not step");

  a_read_fetch: assert property (@(posedge core_clk) disable iff (!rstn)
    (ce && byte_done && state_r == radio_cfg_pkg::PH_RDATA) |=>
      tx_shift_r == read_reg($past(regs_r), $past(addr_nxt)))
    else $error("burst read fetched wrong byte");

  a_channel_product: assert property (@(posedge core_clk) disable iff (!rstn)
    ce |=> channel_offset == ({8'h00, $past(channel_index)} * {8'h00, $past(channel_step)}))
    else $error("carrier offset is not index times step");

  a_band_divide: assert property (@(posedge core_clk) disable iff (!rstn)
    out_of_loop_divide == (regs_r[radio_cfg_pkg::ADDR_SYN_TOP][4] ? 4'h8 : 4'h4))
    else $error("band divide factor wrong");

  a_idle_header: assert property (@(posedge core_clk) disable iff (!rstn)
    (ce && chip_select_low) |=> (state_r == radio_cfg_pkg::PH_CMD && bit_cnt_r == 3'h0))
    else $error("serial framing not reset while deselected");

endmodule

`default_nettype wire

// File: tb/host_spi_model.sv
`timescale 1ns/10ps
`default_nettype none

module host_spi_model (
  // clock
  input  wire logic       core_clk,
  // serial port
  output logic            chip_select_low,
  output logic            sclk,
  output logic            mosi,
  input  wire logic       miso,
  // read results
  output logic            rd_valid,
  output logic      [7:0] rd_data
);
  initial begin
    chip_select_low = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
    rd_valid = 1'b0;
    rd_data = 8'h00;
  end

  // mode 0, msb first; each sclk phase lasts two core cycles
  task automatic xfer(input logic [7:0] tx, input int nbits, input logic note);
    logic [7:0] rx;
    rx = 8'h00;
    for (int i = 7; i > 7 - nbits; i--) begin
      @(negedge core_clk);
      sclk = 1'b0;
      mosi = tx[i];
      @(negedge core_clk);
      @(negedge core_clk);
      sclk = 1'b1;
      rx[i] = miso;
      @(negedge core_clk);
    end
    @(negedge core_clk);
    sclk = 1'b0;
    if (note) begin
      rd_data = rx;
      rd_valid = 1'b1;
      @(negedge core_clk);
      rd_valid = 1'b0;
    end
  endtask

  // select held low for the whole burst
  task automatic frame_start;
    @(negedge core_clk);
    chip_select_low = 1'b0;
  endtask

  task automatic frame_end;
    @(negedge core_clk);
    chip_select_low = 1'b1;
    mosi = ~mosi; // idle data line flips so a stale bit never looks valid
    @(negedge core_clk);
  endtask
endmodule

`default_nettype wire

// File: tb/radio_pin_synth_mod_config_regs_test.sv
`timescale 1ns/10ps
`default_nettype none

module radio_pin_synth_mod_config_regs_test;
  logic        core_clk, rstn, ce, chip_select_low, sclk, mosi, miso, miso_oe_n;
  logic        interrupt_request_low, por_low, synth_band_divide_select;
  logic        power_amp_interpolator_on, rd_valid;
  logic [31:0] internal_signals;
  logic [3:0]  pin_in, pin_out, pin_oe_n, pin_high_drive, pin_in_level, pin_seen;
  logic [2:0]  charge_pump_current_code;
  logic [3:0]  out_of_loop_divide, rate_exponent, modulation_kind;
  logic [27:0] pll_divider_word;
  logic [7:0]  analog_intermediate_freq, digital_intermediate_freq;
  logic [7:0]  channel_step, channel_index, rd_data;
  logic [15:0] channel_offset, rate_mantissa;
  int          err_count, check_count;
  logic [7:0]  exp_q[$];
  logic [7:0]  wq[$];
  logic [7:0]  shadow[0:17];
  localparam logic [7:0] DEFAULTS[0:17] = '{8'h0a, 8'ha2, 8'ha2, 8'ha2, 8'h00, 8'h42,
    8'h16, 8'h27, 8'h62, 8'h2a, 8'hb8, 8'h00, 8'h3f, 8'h00, 8'h83, 8'h2b, 8'h77, 8'h00};
  // pin bit 2 reserved, gaps hold nothing, amplifier byte has bit 7 only
  localparam logic [7:0] MASKS[0:17] = '{8'hfb, 8'hfb, 8'hfb, 8'hfb, 8'h00, 8'hff,
    8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h00, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h80};

  always #12.5 core_clk = ~core_clk;

  radio_cfg_regs #(.PIN_COUNT(4)) DUT (.core_clk(core_clk), .rstn(rstn), .ce(ce),
    .chip_select_low(chip_select_low), .sclk(sclk), .mosi(mosi), .miso(miso),
    .miso_oe_n(miso_oe_n), .interrupt_request_low(interrupt_request_low),
    .por_low(por_low), .internal_signals(internal_signals), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_high_drive(pin_high_drive),
    .pin_in_level(pin_in_level), .charge_pump_current_code(charge_pump_current_code),
    .synth_band_divide_select(synth_band_divide_select),
    .out_of_loop_divide(out_of_loop_divide), .pll_divider_word(pll_divider_word),
    .analog_intermediate_freq(analog_intermediate_freq),
    .digital_intermediate_freq(digital_intermediate_freq), .channel_step(channel_step),
    .channel_index(channel_index), .channel_offset(channel_offset),
    .rate_mantissa(rate_mantissa), .rate_exponent(rate_exponent),
    .modulation_kind(modulation_kind), .power_amp_interpolator_on(power_amp_interpolator_on));

  host_spi_model host (.core_clk(core_clk), .chip_select_low(chip_select_low),
    .sclk(sclk), .mosi(mosi), .miso(miso), .rd_valid(rd_valid), .rd_data(rd_data));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // read bytes arrive one at a time; compare against the oldest note
  always @(posedge core_clk) if (rd_valid === 1'b1) begin
    if (exp_q.size() == 0) check("unexpected read", 1, 0);
    else check("read byte", rd_data, exp_q.pop_front());
    check("miso driven", miso_oe_n, 1'b0);
  end

  function automatic logic pin_src(input logic [4:0] f);
    case (f)
      radio_cfg_pkg::FUNC_IRQ: return interrupt_request_low;
      radio_cfg_pkg::FUNC_POR: return por_low;
      radio_cfg_pkg::FUNC_VDD: return 1'b1;
      radio_cfg_pkg::FUNC_GND: return 1'b0;
      default: return internal_signals[f];
    endcase
  endfunction

  task automatic shake;
    @(negedge core_clk);
    interrupt_request_low = 1'($urandom);
    por_low = 1'($urandom);
    internal_signals = $urandom;
    pin_in = 4'($urandom);
  endtask

  task automatic check_fields;
    repeat (3) @(negedge core_clk);
    check("pll word", pll_divider_word, {shadow[5][3:0], shadow[6], shadow[7], shadow[8]});
    check("cp code", charge_pump_current_code, shadow[5][7:5]);
    check("band sel", synth_band_divide_select, shadow[5][4]);
    check("band div", out_of_loop_divide, shadow[5][4] ? 4'h8 : 4'h4);
    check("if ana", analog_intermediate_freq, shadow[9]);
    check("if dig", digital_intermediate_freq, shadow[10]);
    check("ch step", channel_step, shadow[12]);
    check("ch index", channel_index, shadow[13]);
    check("ch offset", channel_offset, 16'(shadow[13]) * 16'(shadow[12]));
    check("mantissa", rate_mantissa, {shadow[14], shadow[15]});
    check("mod kind", modulation_kind, shadow[16][7:4]);
    check("exponent", rate_exponent, shadow[16][3:0]);
    check("interp", power_amp_interpolator_on, shadow[17][7]);
    check("miso idle", {miso_oe_n, miso}, 2'b10);
    for (int i = 0; i < 4; i++) begin
      check("pin oe", pin_oe_n[i], !shadow[i][1]);
      check("pin drive", pin_high_drive[i], shadow[i][1:0] == 2'b11);
      check("pin in", pin_in_level[i], shadow[i][1:0] == 2'b01 && pin_in[i]);
      check("pin out", pin_out[i], shadow[i][1] && pin_src(shadow[i][7:3]));
    end
  endtask

  task automatic wr_burst(input logic [7:0] hdr, input logic [7:0] addr);
    host.frame_start();
    host.xfer(hdr, 8, 1'b0);
    host.xfer(addr, 8, 1'b0);
    foreach (wq[i]) begin
      host.xfer(wq[i], 8, 1'b0);
      if (hdr == radio_cfg_pkg::CMD_WRITE && addr + i < 18) shadow[addr + i] = wq[i] & MASKS[addr + i];
    end
    host.frame_end();
  endtask

  task automatic rd_burst(input logic [7:0] addr, input int n);
    host.frame_start();
    host.xfer(radio_cfg_pkg::CMD_READ, 8, 1'b0);
    host.xfer(addr, 8, 1'b0);
    for (int i = 0; i < n; i++) begin
      exp_q.push_back(addr + i < 18 ? shadow[addr + i] : 8'h00);
      host.xfer(8'($urandom), 8, 1'b1);
    end
    host.frame_end();
  endtask

  initial begin
    repeat (40000) @(posedge core_clk);
    err_count++;
    $display("watchdog expired");
    end_of_test();
  end

  initial begin
    void'($urandom(32'h7f5a_b3c7));
    core_clk = 1'b0;
    rstn = 1'b0;
    ce = 1'b1;
    {interrupt_request_low, por_low, internal_signals, pin_in} = '0;
    repeat (3) @(negedge core_clk);
    rstn = 1'b1;
    foreach (shadow[i]) shadow[i] = DEFAULTS[i];
    check_fields();
    rd_burst(8'h00, 18);
    $display("test reset values done");
    wq = '{{radio_cfg_pkg::FUNC_IRQ, 3'b111}, {radio_cfg_pkg::FUNC_POR, 3'b010},
           {radio_cfg_pkg::FUNC_VDD, 3'b110}, {radio_cfg_pkg::FUNC_GND, 3'b001}};
    wr_burst(radio_cfg_pkg::CMD_WRITE, radio_cfg_pkg::ADDR_PIN0);
    repeat (3) begin
      shake();
      check_fields();
    end
    pin_seen = pin_out;
    shake();
    ce = 1'b0;
    repeat (3) @(negedge core_clk);
    check("frozen pins", pin_out, pin_seen);
    ce = 1'b1;
    rd_burst(radio_cfg_pkg::ADDR_PIN0, 4);
    $display("test pin functions done");
    repeat (3) begin
      wq.delete();
      repeat (18) wq.push_back(8'($urandom));
      wr_burst(radio_cfg_pkg::CMD_WRITE, 8'h00);
      shake();
      check_fields();
      rd_burst(8'h00, 18);
    end
    $display("test random bursts done");
    wq = '{8'h5a, 8'hff, 8'h3c};
    wr_burst(radio_cfg_pkg::CMD_WRITE, radio_cfg_pkg::ADDR_MOD);
    wr_burst(8'h02, radio_cfg_pkg::ADDR_CH_IDX);
    host.frame_start();
    host.xfer(radio_cfg_pkg::CMD_WRITE, 8, 1'b0);
    host.xfer(radio_cfg_pkg::ADDR_IF_ANA, 8, 1'b0);
    host.xfer(8'h5a, 5, 1'b0);
    host.frame_end();
    check_fields();
    rd_burst(radio_cfg_pkg::ADDR_IF_ANA, 12);
    $display("test refused accesses done");
    check("reads pending", exp_q.size(), 0);
    end_of_test();
  end
endmodule

`default_nettype wire
